// File: src/cbsg_map.vh
`ifndef CBSG_MAP_VH
`define CBSG_MAP_VH

// ****************************************
// Bus register map
// ****************************************
`define CBSG_ADDR_W 12
`define CBSG_OFS_CTRL 12'h000
`define CBSG_OFS_STATUS 12'h004
`define CBSG_OFS_CTRL_IDX 12'h000
`define CBSG_OFS_STATUS_IDX 12'h001

// ****************************************
// Control fields
// ****************************************
`define CBSG_CTRL_EXT_BIT 0
`define CBSG_CTRL_NSRC_LO 1
`define CBSG_CTRL_NSRC_HI 2
`define CBSG_CTRL_GF_BIT 3
`define CBSG_CTRL_SELCON_BIT 4
`define CBSG_CTRL_ENACON_BIT 5
`define CBSG_CTRL_MASK 32'h0000_003F

// ****************************************
// Status fields
// ****************************************
`define CBSG_ST_CUR_LO 0
`define CBSG_ST_REQ_LO 2
`define CBSG_ST_PEND_BIT 4
`define CBSG_ST_ENA_BIT 5
`define CBSG_ST_ACT_LO 6

// ****************************************
// Reset values
// ****************************************
`define CBSG_RST_EXT 1'h0
`define CBSG_RST_NSRC 2'h3
`define CBSG_RST_GF 1'h1
`define CBSG_RST_SELCON 1'h0
`define CBSG_RST_ENACON 1'h0
`define CBSG_SEL_ZERO 2'h0
`define CBSG_WORD_ZERO 32'h0000_0000

// ****************************************
// Timing
// ****************************************
`define CBSG_CLK_PERIOD_NS 10
`define CBSG_ACT_TIME_NS 1000
// Activity window in clocks, sized to the counter
`define CBSG_ACT_CYCLES 8'h64
`define CBSG_ACT_W 8

// ****************************************
// Switch states
// ****************************************
`define CBSG_ST_RUN 1'h0
`define CBSG_ST_SWITCH 1'h1

`endif

// File: src/cbsg_sync.v
`timescale 1ns/10ps

// ****************************************
// Two-stage synchroniser
// ****************************************
module cbsg_sync #(
    parameter W = 7
) (
    input wire clk_i,
    input wire rst_n_i,
    input wire [W-1:0] d_i,
    output wire [W-1:0] q_o
);
    reg [W-1:0] stage1;
    reg [W-1:0] stage2;

    // First stage feeds only the second; metastability is contained here
    always @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            stage1 <= {W{1'b0}};
            stage2 <= {W{1'b0}};
        end
        else
        begin
            stage1 <= d_i;
            stage2 <= stage1;
        end
    end

    assign q_o = stage2;
endmodule // cbsg_sync

// File: src/cbsg_clock_buffer.v
`timescale 1ns/10ps
`include "cbsg_map.vh"

module cbsg_clock_buffer (
    input wire clk_i,
    input wire rst_n_i,
    input wire [3:0] clock_inputs_i,
    input wire [1:0] clock_source_select_i,
    input wire network_enable_i,
    output reg buffered_clock_out_o,
    output wire global_drive_o,
    output wire external_drive_o,
    input wire hsel_i,
    input wire [31:0] haddr_i,
    input wire [1:0] htrans_i,
    input wire hwrite_i,
    input wire [2:0] hsize_i,
    input wire [31:0] hwdata_i,
    input wire hready_i,
    output wire hreadyout_o,
    output wire hresp_o,
    output reg [31:0] hrdata_o
);
    // ****************************************
    // Pin synchronisation
    // ****************************************
    wire [6:0] sync_out;
    wire [3:0] clk_smp;
    wire [1:0] sel_smp;
    wire ena_smp;

    cbsg_sync #(
        .W(7)
    ) u_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .d_i({network_enable_i, clock_source_select_i, clock_inputs_i}),
        .q_o(sync_out)
    );

    assign clk_smp = sync_out[3:0];
    assign sel_smp = sync_out[5:4];
    assign ena_smp = sync_out[6];

    // ****************************************
    // Control register
    // ****************************************
    reg ctrl_ext;
    reg [1:0] ctrl_nsrc;
    reg ctrl_gf;
    reg ctrl_selcon;
    reg ctrl_enacon;

    // ****************************************
    // Bus slave
    // ****************************************
    reg dp_write;
    reg [`CBSG_ADDR_W-1:0] dp_addr;
    wire ap_valid;
    reg [31:0] next_rdata;

    // Zero wait states: every transfer completes in its first data cycle
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign ap_valid = hsel_i & htrans_i[1] & hready_i;

    always @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            dp_write <= 1'b0;
            dp_addr <= {`CBSG_ADDR_W{1'b0}};
            hrdata_o <= `CBSG_WORD_ZERO;
        end
        else
        begin
            dp_write <= ap_valid & hwrite_i;
            if (ap_valid)
            begin
                dp_addr <= haddr_i[`CBSG_ADDR_W-1:0];
            end
            if (ap_valid & ~hwrite_i)
            begin
                hrdata_o <= next_rdata;
            end
        end
    end

    always @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            ctrl_ext <= `CBSG_RST_EXT;
            ctrl_nsrc <= `CBSG_RST_NSRC;
            ctrl_gf <= `CBSG_RST_GF;
            ctrl_selcon <= `CBSG_RST_SELCON;
            ctrl_enacon <= `CBSG_RST_ENACON;
        end
        else if (dp_write && dp_addr == `CBSG_OFS_CTRL)
        begin
            ctrl_ext <= hwdata_i[`CBSG_CTRL_EXT_BIT];
            ctrl_nsrc <= hwdata_i[`CBSG_CTRL_NSRC_HI:`CBSG_CTRL_NSRC_LO];
            ctrl_gf <= hwdata_i[`CBSG_CTRL_GF_BIT];
            ctrl_selcon <= hwdata_i[`CBSG_CTRL_SELCON_BIT];
            ctrl_enacon <= hwdata_i[`CBSG_CTRL_ENACON_BIT];
        end
    end

    // ****************************************
    // Mode decode
    // ****************************************
    wire global_mode;
    wire [1:0] eff_nsrc;
    wire [3:0] src_mask;

    // A connected select forces the global network
    assign global_mode = ~ctrl_ext | ctrl_selcon;
    assign external_drive_o = ~global_mode;
    assign global_drive_o = global_mode;
    assign eff_nsrc = global_mode ? ctrl_nsrc : `CBSG_SEL_ZERO;

    // ****************************************
    // Per-input activity
    // ****************************************
    reg [3:0] smp_d;
    wire [3:0] active;
    wire [3:0] running;

    always @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            smp_d <= 4'h0;
        end
        else
        begin
            smp_d <= clk_smp;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1)
        begin : g_act
            reg [`CBSG_ACT_W-1:0] idle_cnt;
            wire edge_seen;

            assign src_mask[gi] = (gi <= eff_nsrc);
            assign edge_seen = clk_smp[gi] ^ smp_d[gi];
            // Saturates so a stopped clock stays marked idle
            always @(posedge clk_i)
            begin
                if (!rst_n_i)
                begin
                    idle_cnt <= `CBSG_ACT_CYCLES;
                end
                else if (edge_seen)
                begin
                    idle_cnt <= {`CBSG_ACT_W{1'b0}};
                end
                else if (idle_cnt != `CBSG_ACT_CYCLES)
                begin
                    idle_cnt <= idle_cnt + 1'b1;
                end
            end
            assign running[gi] = (idle_cnt != `CBSG_ACT_CYCLES);
            assign active[gi] = src_mask[gi] & running[gi];
        end
    endgenerate

    // ****************************************
    // Selection capture
    // ****************************************
    reg [1:0] req_sel;
    wire [1:0] sel_in;

    assign sel_in = ctrl_selcon ? sel_smp : `CBSG_SEL_ZERO;

    always @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            req_sel <= `CBSG_SEL_ZERO;
        end
        else if (!global_mode)
        begin
            req_sel <= `CBSG_SEL_ZERO;
        end
        else if (active[0] && sel_in <= eff_nsrc)
        begin
            // Held while input zero is quiet; out-of-range codes ignored
            req_sel <= sel_in;
        end
    end

    // ****************************************
    // Switchover
    // ****************************************
    reg sw_state;
    reg [1:0] cur_sel;
    reg [1:0] next_cur_sel;
    reg next_sw_state;
    wire cur_low;
    wire new_low;

    assign cur_low = ~clk_smp[cur_sel];
    assign new_low = ~clk_smp[req_sel];

    always @*
    begin
        next_cur_sel = cur_sel;
        next_sw_state = sw_state;
        case (sw_state)
            `CBSG_ST_RUN:
            begin
                if (req_sel != cur_sel)
                begin
                    next_sw_state = `CBSG_ST_SWITCH;
                end
            end
            `CBSG_ST_SWITCH:
            begin
                if (req_sel == cur_sel)
                begin
                    next_sw_state = `CBSG_ST_RUN;
                end
                else if (!ctrl_gf)
                begin
                    // Plain mux: fast, may chop a phase
                    next_cur_sel = req_sel;
                    next_sw_state = `CBSG_ST_RUN;
                end
                // Unmasked, so a source outside a narrowed count can still leave
                else if (running[cur_sel] && cur_low && new_low)
                begin
                    // Both low: old phase done, new one starts whole
                    next_cur_sel = req_sel;
                    next_sw_state = `CBSG_ST_RUN;
                end
            end
            default:
            begin
                next_sw_state = `CBSG_ST_RUN;
            end
        endcase
    end

    always @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            sw_state <= `CBSG_ST_RUN;
            cur_sel <= `CBSG_SEL_ZERO;
        end
        else
        begin
            sw_state <= next_sw_state;
            cur_sel <= next_cur_sel;
        end
    end

    // ****************************************
    // Enable gating and output
    // ****************************************
    reg net_ena;
    wire ena_req;

    assign ena_req = ctrl_enacon ? ena_smp : 1'b1;

    always @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            net_ena <= 1'b1;
            buffered_clock_out_o <= 1'b0;
        end
        else
        begin
            // Gate moves only in the low phase, never truncating a high
            if (cur_low)
            begin
                net_ena <= ena_req;
            end
            buffered_clock_out_o <= net_ena & clk_smp[cur_sel];
        end
    end

    // ****************************************
    // Read mux
    // ****************************************
    always @*
    begin
        next_rdata = `CBSG_WORD_ZERO;
        case (haddr_i[`CBSG_ADDR_W-1:0])
            `CBSG_OFS_CTRL:
            begin
                next_rdata[`CBSG_CTRL_EXT_BIT] = ctrl_ext;
                next_rdata[`CBSG_CTRL_NSRC_HI:`CBSG_CTRL_NSRC_LO] = ctrl_nsrc;
                next_rdata[`CBSG_CTRL_GF_BIT] = ctrl_gf;
                next_rdata[`CBSG_CTRL_SELCON_BIT] = ctrl_selcon;
                next_rdata[`CBSG_CTRL_ENACON_BIT] = ctrl_enacon;
            end
            `CBSG_OFS_STATUS:
            begin
                next_rdata[`CBSG_ST_CUR_LO+1:`CBSG_ST_CUR_LO] = cur_sel;
                next_rdata[`CBSG_ST_REQ_LO+1:`CBSG_ST_REQ_LO] = req_sel;
                next_rdata[`CBSG_ST_PEND_BIT] = sw_state;
                next_rdata[`CBSG_ST_ENA_BIT] = net_ena;
                next_rdata[`CBSG_ST_ACT_LO+3:`CBSG_ST_ACT_LO] = active;
            end
            default:
            begin
                next_rdata = `CBSG_WORD_ZERO;
            end
        endcase
    end
endmodule // cbsg_clock_buffer

// File: test/cbsg_props.sv
`timescale 1ns/10ps

// ****************************************
// Port checker
// ****************************************
module cbsg_props (
    input wire clk_i,
    input wire rst_n_i,
    input wire [3:0] clock_inputs_i,
    input wire buffered_clock_out_o,
    input wire global_drive_o,
    input wire external_drive_o,
    input wire hsel_i,
    input wire [31:0] haddr_i,
    input wire [1:0] htrans_i,
    input wire hwrite_i,
    input wire hready_i,
    input wire hreadyout_o,
    input wire hresp_o,
    input wire [31:0] hrdata_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    wire rd_ph;
    assign rd_ph = hsel_i && htrans_i[1] && hready_i && !hwrite_i;
    property p_ready;
        hreadyout_o;
    endproperty
    a_ready: assert property (p_ready) else $error("bus stalled");
    property p_okay;
        !hresp_o;
    endproperty
    a_okay: assert property (p_okay) else $error("bus error response");
    property p_drive;
        global_drive_o != external_drive_o;
    endproperty
    a_drive: assert property (p_drive) else $error("drive paths overlap");
    property p_rst;
        $rose(rst_n_i) |-> global_drive_o && !external_drive_o && !buffered_clock_out_o;
    endproperty
    a_rst: assert property (p_rst) else $error("bad state after reset");
    property p_src;
        buffered_clock_out_o |-> $past(|clock_inputs_i, 3);
    endproperty
    a_src: assert property (p_src) else $error("output high with no source");
    property p_high;
        $rose(buffered_clock_out_o) |-> buffered_clock_out_o [*4];
    endproperty
    a_high: assert property (p_high) else $error("runt high pulse");
    property p_unmapped;
        rd_ph && haddr_i[11:0] > 12'h004 |=> hrdata_o == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_rd_hold;
        !rd_ph |=> $stable(hrdata_o);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    c_ext: cover property ($rose(external_drive_o));
    c_out: cover property ($rose(buffered_clock_out_o));
    c_rd: cover property (rd_ph);
endmodule // cbsg_props

// File: test/cbsg_clk_src.sv
`timescale 1ns/10ps

// ****************************************
// Clock sources
// ****************************************
module cbsg_clk_src (
    input wire [3:0] run_i,
    output logic [3:0] clk_o
);
    initial clk_o = 4'h0;
    // Even half periods keep edges off the sampling edge
    for (genvar k = 0; k < 4; k++)
    begin : g_src
        always #(42 + 10 * k) clk_o[k] = run_i[k] ? ~clk_o[k] : clk_o[k];
    end
endmodule // cbsg_clk_src

// File: test/tb_top.sv
`timescale 1ns/10ps

// ****************************************
// Bench
// ****************************************
module tb_top;
    typedef struct {logic [31:0] ctrl; logic [1:0] s; logic [1:0] cur; logic x;} cbsg_row_t;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [1:0] sel = 2'h0;
    logic ena = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [3:0] run = 4'hF;
    logic [11:0] h = 12'h000;
    logic [31:0] q;
    wire [3:0] ci;
    wire out, xdrv, rdy;
    wire [31:0] hrdata;
    int n_mismatch = 0;
    int cmp_count = 0;
    cbsg_row_t rows [8] = '{
        '{32'h0000_001E, 2'h0, 2'h0, 1'b0},
        '{32'h0000_001E, 2'h1, 2'h1, 1'b0},
        '{32'h0000_001E, 2'h2, 2'h2, 1'b0},
        '{32'h0000_001E, 2'h3, 2'h3, 1'b0},
        '{32'h0000_000E, 2'h3, 2'h0, 1'b0},
        '{32'h0000_000F, 2'h2, 2'h0, 1'b1},
        '{32'h0000_001F, 2'h1, 2'h1, 1'b0},
        '{32'h0000_001A, 2'h3, 2'h1, 1'b0}
    };

    cbsg_clk_src i_src (.run_i(run), .clk_o(ci));
    cbsg_clock_buffer i_dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .clock_inputs_i(ci), .clock_source_select_i(sel),
        .network_enable_i(ena), .buffered_clock_out_o(out), .global_drive_o(),
        .external_drive_o(xdrv), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(rdy),
        .hreadyout_o(rdy), .hresp_o(), .hrdata_o(hrdata));

    always #5 clk_i = ~clk_i;
    // Oldest nibble is the input the output should show now
    always @(posedge clk_i) h <= {h[7:0], ci};

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s exp %h seen %h", n, e, s);
        end
    endtask

    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {20'h0_0000, a};
        @(posedge clk_i);
        while (rdy !== 1'b1) @(posedge clk_i);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk_i);
        while (rdy !== 1'b1) @(posedge clk_i);
        q = hrdata;
    endtask

    task automatic follow(input int k, input logic en);
        repeat (16)
        begin
            @(negedge clk_i);
            chk("clock out", {31'h0, out}, {31'h0, en & h[8 + k]});
        end
        @(posedge clk_i);
    endtask

    task automatic status(input logic [31:0] e);
        repeat (60) @(posedge clk_i);
        bus(1'b0, 12'h004, 32'h0000_0000);
        chk("status", q & 32'h0000_001F, e);
    endtask

    task automatic summarize();
        $display("TB: mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        bus(1'b0, 12'h000, 32'h0000_0000);
        chk("ctrl reset", q, 32'h0000_000E);
        bus(1'b0, 12'h004, 32'h0000_0000);
        chk("status reset", q & 32'h0000_001F, 32'h0000_0000);
        follow(0, 1'b1);
        foreach (rows[i])
        begin
            bus(1'b1, 12'h000, rows[i].ctrl);
            sel <= rows[i].s;
            status({28'h000_0000, rows[i].cur, rows[i].cur});
            chk("ext drive", {31'h0, xdrv}, {31'h0, rows[i].x});
            follow(rows[i].cur, 1'b1);
        end
        // Enable pin now counts: low must silence the output
        bus(1'b1, 12'h000, 32'h0000_003E);
        sel <= 2'h0;
        status(32'h0000_0000);
        follow(0, 1'b0);
        ena <= 1'b1;
        repeat (20) @(posedge clk_i);
        follow(0, 1'b1);
        bus(1'b1, 12'h004, 32'hFFFF_FFFF);
        bus(1'b0, 12'h00C, 32'h0000_0000);
        chk("unmapped", q, 32'h0000_0000);
        sel <= 2'h1;
        status(32'h0000_0005);
        // Current source frozen: switch must hang with request pending
        run <= 4'hD;
        repeat (240) @(posedge clk_i);
        sel <= 2'h2;
        status(32'h0000_0019);
        run <= 4'hF;
        status(32'h0000_000A);
        // Input zero frozen: new code must not be taken
        run <= 4'hE;
        repeat (240) @(posedge clk_i);
        sel <= 2'h3;
        status(32'h0000_000A);
        run <= 4'hF;
        status(32'h0000_000F);
        follow(3, 1'b1);
        // Second reset mid-run: all back to input zero
        rst_n_i <= 1'b0;
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        bus(1'b0, 12'h000, 32'h0000_0000);
        chk("ctrl re-reset", q, 32'h0000_000E);
        status(32'h0000_0000);
        follow(0, 1'b1);
        summarize();
    end

    initial
    begin
        #100_000;
        n_mismatch++;
        summarize();
    end
endmodule // tb_top

bind cbsg_clock_buffer cbsg_props i_props (.clk_i, .rst_n_i, .clock_inputs_i,
    .buffered_clock_out_o, .global_drive_o, .external_drive_o, .hsel_i, .haddr_i,
    .htrans_i, .hwrite_i, .hready_i, .hreadyout_o, .hresp_o, .hrdata_o);
